//--- tpb_regs.vh
`ifndef TPB_REGS_VH
`define TPB_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TPB_PRESC_OFS 12'h000
`define TPB_GP_MASK_OFS 12'h004
`define TPB_GP_STAT_OFS 12'h008
`define TPB_EVT_CFG_OFS 12'h00c
`define TPB_FS_CTRL_OFS 12'h010
`define TPB_FS_BOUND_OFS 12'h014
`define TPB_FS_STAT_OFS 12'h018
`define TPB_FS_CNT_OFS 12'h01c
`define TPB_WD_CTRL_OFS 12'h020
`define TPB_WD_BOUND_OFS 12'h024
`define TPB_WD_CNT_OFS 12'h028
`define TPB_GP_BASE 12'h040
`define TPB_GP_END 12'h0a0
`define TPB_PWM_BASE 12'h0c0
`define TPB_PWM_END 12'h120

// ----------------------------------------------------------------
// Fields within one timer or PWM slot (address bits 3:2)
// ----------------------------------------------------------------
`define TPB_SLOT_CTRL 2'h0
`define TPB_SLOT_LO 2'h1
`define TPB_SLOT_HI 2'h2
`define TPB_SLOT_CNT 2'h3
`define TPB_PWM_MAX 2'h1
`define TPB_PWM_THR 2'h2

// ----------------------------------------------------------------
// Bit positions
// ----------------------------------------------------------------
`define TPB_PRESC_EN_BIT 31
`define TPB_CHAIN_BIT 0
`define TPB_PWM_EN_BIT 0
`define TPB_EVT_A_OUT_BIT 0
`define TPB_EVT_A_FALL_BIT 1
`define TPB_EVT_B_OUT_BIT 2
`define TPB_EVT_B_FALL_BIT 3
`define TPB_FS_SEL_TX_BIT 0
`define TPB_FS_EN0_BIT 1
`define TPB_FS_EN1_BIT 2
`define TPB_WD_EN_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TPB_RST_32 32'h00000000
`define TPB_RST_GP_HI 32'hffffffff
`define TPB_RST_WD_BOUND 32'hffffffff
`define TPB_RST_FS_BOUND 16'hffff

`endif

//--- tpb_timer.v
// Summary of operation
// - Six 32-bit counters, one interrupt each
// - Bound write reloads counter with lower bound
// - Normal mode counts every clock edge
// - Reaching upper bound: timeout, interrupt, reload
// - Counters 2,3,5 chain on 0,1,4 timeouts
// - Chain bits on 2,3,5; count writable 0,1,4
// - Frame-sync counter counts while sync high
// - Frame-sync interrupt from either pulse, status
// - Watchdog expiry gives level hard reset
// - Input pins clock counters 1 and 4
// - Output pins toggle on counter 3/5 timeout
// - Output mode unchained: counter counts clock
// - Pin input synchronised twice, then edge detect
// - Masks gate interrupts; status records timeouts
// - Six PWM channels, own maximum and threshold
// - Prescaler pulses at match, restarts from zero
// - PWM counter wraps at max or on writes
// - PWM high at threshold, low at wrap/disable
// - Period follows prescaler and maximum settings
//
// The APB register port was decided locally.
`include "tpb_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module tpb_timer #(
    parameter PWM_W = 16 // Width of PWM maximum and threshold
) (
    input wire core_clk, // System clock, 125 MHz
    input wire rst, // Synchronous reset, active high
    input wire psel, // APB select
    input wire penable, // APB access phase
    input wire pwrite, // APB direction, high for write
    input wire [11:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error on unmapped address
    input wire rx_fsync, // Receive frame sync
    input wire tx_fsync, // Transmit frame sync
    input wire event_pin_a_in, // Event pin A level in
    output reg event_pin_a_out, // Event pin A driven level
    output reg event_pin_a_oe, // Event pin A drive enable
    input wire event_pin_b_in, // Event pin B level in
    output reg event_pin_b_out, // Event pin B driven level
    output reg event_pin_b_oe, // Event pin B drive enable
    output reg [5:0] gp_irq, // Per-counter interrupts, masked
    output reg combined_timer_irq, // Any masked counter timeout
    output reg fsync_irq, // Frame-sync interrupt
    output reg wdog_reset, // Watchdog hard reset, level
    output reg [5:0] pwm_out // PWM outputs to LED drivers
);

    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------
    localparam [5:0] GP_CNT_WRITABLE = 6'h13; // Counters 0, 1 and 4
    localparam [5:0] GP_CHAINABLE = 6'h2c; // Counters 2, 3 and 5

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg [31:0] gp_cnt [0:5]; // Counter values
    reg [31:0] gp_lo [0:5]; // Lower bounds
    reg [31:0] gp_hi [0:5]; // Upper bounds
    reg [5:0] gp_chain; // Chain enables
    reg [5:0] gp_mask; // Interrupt masks
    reg [5:0] gp_stat; // Sticky timeout status
    reg [3:0] evt_cfg; // Pin direction and edge select
    reg [2:0] fs_ctrl; // Frame-sync select and pulse enables
    reg [15:0] fs_bound; // Frame-sync bound
    reg [15:0] fs_cnt; // Frame-sync counter
    reg [1:0] fs_stat; // Frame-sync pulse status
    reg wd_en; // Watchdog enable
    reg [31:0] wd_bound; // Watchdog expiry value
    reg [31:0] wd_cnt; // Watchdog counter
    reg presc_en; // Prescaler enable
    reg [7:0] presc_div; // Prescaler match value
    reg [7:0] presc_cnt; // Prescaler count
    reg [5:0] pwm_en; // PWM channel enables
    reg [PWM_W-1:0] pwm_max [0:5]; // PWM maxima
    reg [PWM_W-1:0] pwm_thr [0:5]; // PWM thresholds
    reg [PWM_W-1:0] pwm_cnt [0:5]; // PWM counters
    reg sync_a1, sync_a2, prev_a; // Pin A synchroniser and history
    reg sync_b1, sync_b2, prev_b; // Pin B synchroniser and history
    reg [31:0] next_prdata; // Read mux result
    reg next_err; // Unmapped access
    integer i;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire access = psel & penable & pready; // Completing transfer
    wire wr = access & pwrite; // Write takes effect
    wire [11:0] gp_off = paddr - `TPB_GP_BASE; // Offset into timers
    wire [11:0] pwm_off = paddr - `TPB_PWM_BASE; // Offset into PWM
    wire gp_sel = (paddr >= `TPB_GP_BASE) && (paddr < `TPB_GP_END);
    wire pwm_sel = (paddr >= `TPB_PWM_BASE) && (paddr < `TPB_PWM_END);
    wire [1:0] fld = paddr[3:2]; // Field in a slot
    wire [5:0] gp_hit = (wr && gp_sel) ? (6'h01 << gp_off[6:4]) : 6'h00;
    wire [5:0] pwm_hit = (wr && pwm_sel) ? (6'h01 << pwm_off[6:4]) : 6'h00;
    wire presc_wr = wr && (paddr == `TPB_PRESC_OFS);

    // ----------------------------------------------------------------
    // Event pin edge detection
    // ----------------------------------------------------------------
    wire a_is_out = evt_cfg[`TPB_EVT_A_OUT_BIT];
    wire b_is_out = evt_cfg[`TPB_EVT_B_OUT_BIT];
    wire edge_a = evt_cfg[`TPB_EVT_A_FALL_BIT] ? (prev_a & ~sync_a2) : (sync_a2 & ~prev_a);
    wire edge_b = evt_cfg[`TPB_EVT_B_FALL_BIT] ? (prev_b & ~sync_b2) : (sync_b2 & ~prev_b);

    // Two flops then a history flop; edges compare the second stage with the history flop
    always @(posedge core_clk) begin
        if (rst) begin
            sync_a1 <= 1'b0;
            sync_a2 <= 1'b0;
            prev_a <= 1'b0;
            sync_b1 <= 1'b0;
            sync_b2 <= 1'b0;
            prev_b <= 1'b0;
        end else begin
            sync_a1 <= event_pin_a_in;
            sync_a2 <= sync_a1;
            prev_a <= sync_a2;
            sync_b1 <= event_pin_b_in;
            sync_b2 <= sync_b1;
            prev_b <= sync_b2;
        end
    end

    // ----------------------------------------------------------------
    // Counter tick sources and timeouts
    // ----------------------------------------------------------------
    wire [5:0] gp_tick; // Advance strobe per counter
    wire [5:0] gp_to; // Timeout per counter
    assign gp_tick[0] = 1'b1;
    assign gp_tick[1] = a_is_out ? 1'b1 : edge_a;
    assign gp_tick[2] = gp_chain[2] ? gp_to[0] : 1'b1;
    assign gp_tick[3] = gp_chain[3] ? gp_to[1] : 1'b1;
    assign gp_tick[4] = b_is_out ? 1'b1 : edge_b;
    assign gp_tick[5] = gp_chain[5] ? gp_to[4] : 1'b1;

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : gen_to
            // Timeout on the advance that finds the upper bound
            assign gp_to[g] = gp_tick[g] && (gp_cnt[g] == gp_hi[g]);
        end
    endgenerate

    // ----------------------------------------------------------------
    // General-purpose counters and their registers
    // ----------------------------------------------------------------
    // A bound write wins over counting, so the reload is never lost
    always @(posedge core_clk) begin
        for (i = 0; i < 6; i = i + 1) begin
            if (rst) begin
                gp_cnt[i] <= `TPB_RST_32;
                gp_lo[i] <= `TPB_RST_32;
                gp_hi[i] <= `TPB_RST_GP_HI;
            end else if (gp_hit[i] && fld == `TPB_SLOT_LO) begin
                gp_lo[i] <= pwdata;
                gp_cnt[i] <= pwdata;
            end else if (gp_hit[i] && fld == `TPB_SLOT_HI) begin
                gp_hi[i] <= pwdata;
                gp_cnt[i] <= gp_lo[i];
            end else if (gp_hit[i] && fld == `TPB_SLOT_CNT && GP_CNT_WRITABLE[i]) begin
                gp_cnt[i] <= pwdata;
            end else if (gp_to[i]) begin
                gp_cnt[i] <= gp_lo[i];
            end else if (gp_tick[i]) begin
                gp_cnt[i] <= gp_cnt[i] + 32'h00000001;
            end
        end
    end

    // Chain bits, masks and pin configuration
    always @(posedge core_clk) begin
        if (rst) begin
            gp_chain <= 6'h00;
            gp_mask <= 6'h00;
            evt_cfg <= 4'h0;
        end else begin
            for (i = 0; i < 6; i = i + 1) begin
                if (gp_hit[i] && fld == `TPB_SLOT_CTRL && GP_CHAINABLE[i]) begin
                    gp_chain[i] <= pwdata[`TPB_CHAIN_BIT];
                end
            end
            if (wr && paddr == `TPB_GP_MASK_OFS) begin
                gp_mask <= pwdata[5:0];
            end
            if (wr && paddr == `TPB_EVT_CFG_OFS) begin
                evt_cfg <= pwdata[3:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Timeout status and interrupt lines
    // ----------------------------------------------------------------
    // A timeout in the clearing cycle stays recorded
    always @(posedge core_clk) begin
        if (rst) begin
            gp_stat <= 6'h00;
            gp_irq <= 6'h00;
            combined_timer_irq <= 1'b0;
        end else begin
            if (wr && paddr == `TPB_GP_STAT_OFS) begin
                gp_stat <= (gp_stat & ~pwdata[5:0]) | gp_to;
            end else begin
                gp_stat <= gp_stat | gp_to;
            end
            gp_irq <= gp_stat & gp_mask;
            combined_timer_irq <= |(gp_stat & gp_mask);
        end
    end

    // ----------------------------------------------------------------
    // Event pin drivers
    // ----------------------------------------------------------------
    // Toggle follows counters 3 and 5 only; 1 and 4 never touch the pins
    always @(posedge core_clk) begin
        if (rst) begin
            event_pin_a_out <= 1'b0;
            event_pin_a_oe <= 1'b0;
            event_pin_b_out <= 1'b0;
            event_pin_b_oe <= 1'b0;
        end else begin
            event_pin_a_oe <= a_is_out;
            event_pin_b_oe <= b_is_out;
            if (a_is_out && gp_to[3]) begin
                event_pin_a_out <= ~event_pin_a_out;
            end
            if (b_is_out && gp_to[5]) begin
                event_pin_b_out <= ~event_pin_b_out;
            end
        end
    end

    // ----------------------------------------------------------------
    // Frame-sync counter
    // ----------------------------------------------------------------
    wire fs_active = fs_ctrl[`TPB_FS_SEL_TX_BIT] ? tx_fsync : rx_fsync;
    wire fs_p0 = fs_active && (fs_cnt == fs_bound); // Bound reached
    wire fs_p1 = fs_active && (fs_cnt == 16'hffff); // Full-range wrap

    // Counts only while the chosen sync is high
    always @(posedge core_clk) begin
        if (rst) begin
            fs_ctrl <= 3'h0;
            fs_bound <= `TPB_RST_FS_BOUND;
            fs_cnt <= 16'h0000;
            fs_stat <= 2'h0;
            fsync_irq <= 1'b0;
        end else begin
            if (wr && paddr == `TPB_FS_CTRL_OFS) begin
                fs_ctrl <= pwdata[2:0];
            end
            if (wr && paddr == `TPB_FS_BOUND_OFS) begin
                fs_bound <= pwdata[15:0];
                fs_cnt <= 16'h0000;
            end else if (fs_p0) begin
                fs_cnt <= 16'h0000;
            end else if (fs_active) begin
                fs_cnt <= fs_cnt + 16'h0001;
            end
            if (wr && paddr == `TPB_FS_STAT_OFS) begin
                fs_stat <= (fs_stat & ~pwdata[1:0]) | {fs_p1, fs_p0};
            end else begin
                fs_stat <= fs_stat | {fs_p1, fs_p0};
            end
            fsync_irq <= (fs_stat[0] & fs_ctrl[`TPB_FS_EN0_BIT]) |
                         (fs_stat[1] & fs_ctrl[`TPB_FS_EN1_BIT]);
        end
    end

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    // Reset output is latched so it cannot glitch; only rst releases it
    always @(posedge core_clk) begin
        if (rst) begin
            wd_en <= 1'b0;
            wd_bound <= `TPB_RST_WD_BOUND;
            wd_cnt <= `TPB_RST_32;
            wdog_reset <= 1'b0;
        end else begin
            if (wr && paddr == `TPB_WD_CTRL_OFS) begin
                wd_en <= pwdata[`TPB_WD_EN_BIT];
            end
            if (wr && paddr == `TPB_WD_BOUND_OFS) begin
                wd_bound <= pwdata;
            end
            if (wr && paddr == `TPB_WD_CNT_OFS) begin
                wd_cnt <= `TPB_RST_32;
            end else if (wd_en && !wdog_reset) begin
                wd_cnt <= wd_cnt + 32'h00000001;
            end
            if (wd_en && wd_cnt == wd_bound) begin
                wdog_reset <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // PWM prescaler and channels
    // ----------------------------------------------------------------
    wire presc_pulse = presc_en && (presc_cnt == presc_div);

    // Shared divider; a write restarts it and all channels
    always @(posedge core_clk) begin
        if (rst) begin
            presc_en <= 1'b0;
            presc_div <= 8'h00;
            presc_cnt <= 8'h00;
        end else if (presc_wr) begin
            presc_en <= pwdata[`TPB_PRESC_EN_BIT];
            presc_div <= pwdata[7:0];
            presc_cnt <= 8'h00;
        end else if (presc_pulse || !presc_en) begin
            presc_cnt <= 8'h00;
        end else begin
            presc_cnt <= presc_cnt + 8'h01;
        end
    end

    // Period is (div+1)*(max+1) clocks by construction
    always @(posedge core_clk) begin
        for (i = 0; i < 6; i = i + 1) begin
            if (rst) begin
                pwm_en[i] <= 1'b0;
                pwm_max[i] <= {PWM_W{1'b0}};
                pwm_thr[i] <= {PWM_W{1'b0}};
                pwm_cnt[i] <= {PWM_W{1'b0}};
                pwm_out[i] <= 1'b0;
            end else if (pwm_hit[i] || presc_wr) begin
                if (pwm_hit[i] && fld == `TPB_SLOT_CTRL) begin
                    pwm_en[i] <= pwdata[`TPB_PWM_EN_BIT];
                end
                if (pwm_hit[i] && fld == `TPB_PWM_MAX) begin
                    pwm_max[i] <= pwdata[PWM_W-1:0];
                end
                if (pwm_hit[i] && fld == `TPB_PWM_THR) begin
                    pwm_thr[i] <= pwdata[PWM_W-1:0];
                end
                pwm_cnt[i] <= {PWM_W{1'b0}};
                pwm_out[i] <= 1'b0;
            end else if (!pwm_en[i]) begin
                pwm_out[i] <= 1'b0;
            end else if (presc_pulse && pwm_cnt[i] == pwm_max[i]) begin
                pwm_cnt[i] <= {PWM_W{1'b0}};
                pwm_out[i] <= 1'b0;
            end else begin
                if (presc_pulse) begin
                    pwm_cnt[i] <= pwm_cnt[i] + {{(PWM_W-1){1'b0}}, 1'b1};
                end
                // Rise together with the count reaching threshold, so high spans thr..max
                if (pwm_cnt[i] == pwm_thr[i] ||
                    (presc_pulse && pwm_cnt[i] + {{(PWM_W-1){1'b0}}, 1'b1} == pwm_thr[i])) begin
                    pwm_out[i] <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always @* begin
        next_prdata = 32'h00000000;
        next_err = 1'b0;
        if (paddr == `TPB_PRESC_OFS) begin
            next_prdata = {presc_en, 23'h000000, presc_div};
        end else if (paddr == `TPB_GP_MASK_OFS) begin
            next_prdata = {26'h0000000, gp_mask};
        end else if (paddr == `TPB_GP_STAT_OFS) begin
            next_prdata = {26'h0000000, gp_stat};
        end else if (paddr == `TPB_EVT_CFG_OFS) begin
            next_prdata = {28'h0000000, evt_cfg};
        end else if (paddr == `TPB_FS_CTRL_OFS) begin
            next_prdata = {29'h00000000, fs_ctrl};
        end else if (paddr == `TPB_FS_BOUND_OFS) begin
            next_prdata = {16'h0000, fs_bound};
        end else if (paddr == `TPB_FS_STAT_OFS) begin
            next_prdata = {30'h00000000, fs_stat};
        end else if (paddr == `TPB_FS_CNT_OFS) begin
            next_prdata = {16'h0000, fs_cnt};
        end else if (paddr == `TPB_WD_CTRL_OFS) begin
            next_prdata = {31'h00000000, wd_en};
        end else if (paddr == `TPB_WD_BOUND_OFS) begin
            next_prdata = wd_bound;
        end else if (paddr == `TPB_WD_CNT_OFS) begin
            next_prdata = wd_cnt;
        end else if (gp_sel) begin
            case (fld)
                `TPB_SLOT_CTRL: next_prdata = {31'h00000000, gp_chain[gp_off[6:4]]};
                `TPB_SLOT_LO: next_prdata = gp_lo[gp_off[6:4]];
                `TPB_SLOT_HI: next_prdata = gp_hi[gp_off[6:4]];
                default: next_prdata = gp_cnt[gp_off[6:4]];
            endcase
        end else if (pwm_sel) begin
            case (fld)
                `TPB_SLOT_CTRL: next_prdata = {31'h00000000, pwm_en[pwm_off[6:4]]};
                `TPB_PWM_MAX: next_prdata = {{(32-PWM_W){1'b0}}, pwm_max[pwm_off[6:4]]};
                `TPB_PWM_THR: next_prdata = {{(32-PWM_W){1'b0}}, pwm_thr[pwm_off[6:4]]};
                default: next_prdata = {{(32-PWM_W){1'b0}}, pwm_cnt[pwm_off[6:4]]};
            endcase
        end else begin
            next_err = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // APB response
    // ----------------------------------------------------------------
    // One wait state: ready rises at the end of the first access cycle
    always @(posedge core_clk) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h00000000 : next_prdata;
            pslverr <= next_err;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule

`default_nettype wire

//--- tpb_timer_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checks of the timer block
// ----------------------------------------
module tpb_timer_props (
    input wire logic core_clk, // Clock
    input wire logic rst, // Sync reset
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Direction
    input wire logic [11:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic [5:0] gp_irq, // Counter irqs
    input wire logic combined_timer_irq, // Combined irq
    input wire logic wdog_reset, // Watchdog reset
    input wire logic [5:0] pwm_out // PWM levels
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_ready_wait: assert property ($rose(penable) && psel |=> pready) else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    a_err_rdzero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("bad err data");
    a_irq_combined: assert property (combined_timer_irq == (|gp_irq)) else $error("irq mismatch");
    a_wdog_held: assert property (wdog_reset |=> wdog_reset) else $error("wdog dropped");
    a_reset_clear: assert property (disable iff (1'b0) rst |=> pwm_out == 6'h0 && gp_irq == 6'h0) else $error("not cleared");
    a_pwm_off: assert property (psel && penable && pready && pwrite && paddr == 12'h0c0 && !pwdata[0]
        |-> ##[1:2] !pwm_out[0]) else $error("pwm stays high");
endmodule
bind tpb_timer tpb_timer_props u_props (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gp_irq(gp_irq), .combined_timer_irq(combined_timer_irq),
    .wdog_reset(wdog_reset), .pwm_out(pwm_out));
`default_nettype wire

//--- tpb_pins.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External source on the two event pins
// ----------------------------------------
module tpb_pins (
    input wire logic core_clk, // Clock
    input wire logic a_oe, // Block drives pin A
    input wire logic a_out, // Block level pin A
    input wire logic b_oe, // Block drives pin B
    input wire logic b_out, // Block level pin B
    output logic a_lvl, // Wire level pin A
    output logic b_lvl // Wire level pin B
);
    logic drv_a = 1'b0; // Source level A
    logic drv_b = 1'b0; // Source level B
    // Whoever enables wins the wire
    assign a_lvl = a_oe ? a_out : drv_a;
    assign b_lvl = b_oe ? b_out : drv_b;
    // Rising edges, each level held two cycles so none is missed
    task automatic edges(input bit sel, input int n);
        repeat (n) begin
            if (sel) drv_b <= 1'b1; else drv_a <= 1'b1;
            repeat (2) @(posedge core_clk);
            if (sel) drv_b <= 1'b0; else drv_a <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
    endtask
endmodule
`default_nettype wire

//--- tpb_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module tpb_timer_test;
    logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0; // Bus side
    logic [11:0] paddr = 0; // Address
    logic [31:0] pwdata = 0, prdata, r; // Data
    logic pready, pslverr, err, a_in, b_in, a_out, a_oe, b_out, b_oe, cti, fsi, wdr; // Outputs
    logic [5:0] gp_irq, pwm_out; // Irqs and PWM
    int n_fail = 0, checks_done = 0, cyc = 0, t1, h, tg; // Counters
    always #4 core_clk = ~core_clk;
    tpb_timer u_tpb_timer (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_fsync(1'b0), .tx_fsync(1'b0), .event_pin_a_in(a_in),
        .event_pin_a_out(a_out), .event_pin_a_oe(a_oe), .event_pin_b_in(b_in),
        .event_pin_b_out(b_out), .event_pin_b_oe(b_oe), .gp_irq(gp_irq),
        .combined_timer_irq(cti), .fsync_irq(fsi), .wdog_reset(wdr), .pwm_out(pwm_out));
    tpb_pins u_pins (.core_clk(core_clk), .a_oe(a_oe), .a_out(a_out), .b_oe(b_oe),
        .b_out(b_out), .a_lvl(a_in), .b_lvl(b_in));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            print_verdict;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // One APB transfer, request held until pready
    // One APB transfer, request held until pready; one idle edge after it
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata; err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge core_clk);
    endtask
    task automatic wait_irq(input int i);
        int t;
        t = 0;
        do @(posedge core_clk); while (gp_irq[i] !== 1'b1 && ++t < 60);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
        apb(0, 12'h000, 0); chk("presc rst", 32'h0, r);
        apb(0, 12'hffc, 0); chk("unmapped", 32'h1, {31'h0, err}); chk("unmapped rd", 0, r);
        apb(1, 12'h068, 32'hf); apb(1, 12'h064, 32'h3);
        repeat (20) @(posedge core_clk);
        apb(0, 12'h008, 0); chk("stat2", 32'h4, r & 32'h4);
        chk("masked irq", 0, {31'h0, gp_irq[2]});
        // Reload fixes the counter's phase before clearing status
        apb(1, 12'h004, 32'h4); apb(1, 12'h064, 32'h3); apb(1, 12'h008, 32'h4);
        @(posedge core_clk);
        chk("w1c", 0, {31'h0, gp_irq[2]});
        chk("combined clr", 0, {31'h0, cti});
        wait_irq(2); t1 = cyc;
        chk("combined set", 1, {31'h0, cti});
        apb(1, 12'h008, 32'h4); wait_irq(2); chk("period", 13, cyc - t1);
        apb(1, 12'h058, 32'h2); apb(1, 12'h054, 32'h0);
        u_pins.edges(0, 2); repeat (6) @(posedge core_clk);
        apb(0, 12'h008, 0); chk("two edges", 0, r & 32'h2);
        u_pins.edges(0, 1); repeat (6) @(posedge core_clk);
        apb(0, 12'h008, 0); chk("three edges", 32'h2, r & 32'h2);
        apb(1, 12'h00c, 32'h1); apb(1, 12'h078, 32'h4); apb(1, 12'h074, 32'h0);
        repeat (10) @(posedge core_clk);
        tg = 0; h = a_out;
        repeat (50) begin @(posedge core_clk); tg += (a_out !== h[0]); h = a_out; end
        chk("pin oe", 1, {31'h0, a_oe}); chk("toggles", 10, tg);
        // max=2, thr=1: high 2 of 3 counts, period 6 clocks
        apb(1, 12'h000, 32'h80000001); apb(1, 12'h0c4, 32'h2);
        apb(1, 12'h0c8, 32'h1); apb(1, 12'h0c0, 32'h1);
        repeat (16) @(posedge core_clk);
        h = 0;
        repeat (78) begin @(posedge core_clk); h += (pwm_out[0] === 1'b1); end
        chk("pwm high", 52, h);
        apb(0, 12'h000, 0); chk("presc rw", 32'h80000001, r);
        apb(1, 12'h0c0, 32'h0); repeat (3) @(posedge core_clk);
        chk("pwm off", 0, {31'h0, pwm_out[0]});
        apb(1, 12'h024, 32'h5); apb(1, 12'h020, 32'h1); repeat (10) @(posedge core_clk);
        chk("wdog", 1, {31'h0, wdr});
        rst <= 1; repeat (2) @(posedge core_clk); rst <= 0; @(posedge core_clk);
        chk("wdog rst", 0, {31'h0, wdr});
        print_verdict;
    end
endmodule
`default_nettype wire
